// *** rtl/hscl_loader.sv ***
// power-on serial memory configuration loader with apb registers
`timescale 1ns/1ns
`default_nettype none
module hscl_loader #(
  parameter logic [15:0] DEF_VENDOR_ID = 16'h0a5a, // arbitrary fallback value
  parameter logic [15:0] DEF_PRODUCT_ID = 16'h05a5 // arbitrary fallback value
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  // straps
  input wire logic i_external_memory_strap_n,
  input wire logic i_bus_power_strap,
  input wire logic i_clock_source_strap,
  // serial memory pins
  output logic o_serial_memory_clock,
  output logic o_serial_memory_clock_oe,
  input wire logic i_serial_memory_data,
  output logic o_serial_memory_data,
  output logic o_serial_memory_data_oe,
  output logic o_pulldown_en,
  // configuration results
  output logic o_cfg_valid,
  output logic [hscl_pkg::ID_W-1:0] o_vendor_identifier,
  output logic [hscl_pkg::ID_W-1:0] o_product_identifier,
  output logic o_ganged,
  output logic [1:0] o_power_mode,
  output logic o_fast_clock_sel,
  // port power
  input wire logic [hscl_pkg::PORTS-1:0] i_overcurrent_n,
  output logic [hscl_pkg::PORTS-1:0] o_port_power,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [hscl_pkg::AW-1:0] i_paddr,
  input wire logic [hscl_pkg::DW-1:0] i_pwdata,
  output logic [hscl_pkg::DW-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq
);
  import hscl_pkg::*;

  localparam logic [PH_W-1:0] PH_LAST = PH_W'(SM_HALF_CYC - 1);
  localparam logic [CNT_W-1:0] TX_LAST = CNT_W'(CMD_BITS - 1);
  localparam logic [CNT_W-1:0] RX_LAST = CNT_W'(RX_BITS - 1);
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);

  function automatic logic addr_hit(input logic [AW-1:0] a);
    case (a)
      ADDR_PORT_EN, ADDR_STATUS, ADDR_IRQ_STAT,
      ADDR_IRQ_MASK, ADDR_IDS, ADDR_WORD0: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  endfunction

  // every pin-side level passes two flops; strap and overcurrent enter inverted so reset is idle
  logic [PORTS+3:0] sync_q;
  hscl_sync2 #(.W(PORTS + 4)) u_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d({~i_external_memory_strap_n, i_bus_power_strap, i_clock_source_strap,
          i_serial_memory_data, ~i_overcurrent_n}),
    .o_q(sync_q)
  );

  logic strap_n_s;
  logic bus_pwr_s;
  logic clk_src_s;
  logic data_s;
  logic [PORTS-1:0] oc_s;
  assign strap_n_s = ~sync_q[PORTS+3];
  assign bus_pwr_s = sync_q[PORTS+2];
  assign clk_src_s = sync_q[PORTS+1];
  assign data_s = sync_q[PORTS];
  assign oc_s = sync_q[PORTS-1:0];

  hscl_state_e st_r;
  logic [CNT_W-1:0] cnt_r;
  logic [PH_W-1:0] ph_r;
  logic sclk_r;
  logic [CMD_BITS-1:0] tx_r;
  logic [RX_BITS-1:0] rx_r;
  logic [RX_BITS-1:0] rx_nxt;
  logic active;
  logic fall_tick;
  logic done_pulse;
  logic skip_pulse;

  assign active = (st_r == ST_SEND) || (st_r == ST_RECV);
  // data was launched on the rise half a period ago, so it is settled here
  assign fall_tick = active && sclk_r && (ph_r == PH_LAST);
  assign rx_nxt = {rx_r[RX_BITS-2:0], data_s};
  assign done_pulse = (st_r == ST_RECV) && fall_tick && (cnt_r == RX_LAST);
  assign skip_pulse = (st_r == ST_WAIT) && (cnt_r == SETTLE_LAST) && strap_n_s;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= ST_WAIT;
      cnt_r <= '0;
    end else begin
      case (st_r)
        ST_WAIT: begin
          if (cnt_r == SETTLE_LAST) begin
            cnt_r <= '0;
            st_r <= strap_n_s ? ST_OFF : ST_SEND;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ST_SEND: begin
          if (fall_tick) begin
            if (cnt_r == TX_LAST) begin
              cnt_r <= '0;
              st_r <= ST_RECV;
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end
        end
        ST_RECV: begin
          if (fall_tick) begin
            if (cnt_r == RX_LAST) begin
              st_r <= ST_DONE;
            end
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ST_DONE: st_r <= ST_DONE;
        ST_OFF: st_r <= ST_OFF;
        default: st_r <= ST_WAIT;
      endcase
    end
  end

  // serial clock from a divider, low when idle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ph_r <= '0;
      sclk_r <= 1'b0;
    end else if (!active) begin
      ph_r <= '0;
      sclk_r <= 1'b0;
    end else if (ph_r == PH_LAST) begin
      ph_r <= '0;
      sclk_r <= ~sclk_r;
    end else begin
      ph_r <= ph_r + 1'b1;
    end
  end

  // command shifts out on falling edges, memory takes it on rises
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_r <= '0;
    end else if (st_r == ST_WAIT) begin
      tx_r <= READ_CMD;
    end else if (st_r == ST_SEND && fall_tick) begin
      tx_r <= {tx_r[CMD_BITS-2:0], 1'b0};
    end
  end

  // the dummy bit falls on the turnaround edge and is not shifted in
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_r <= '0;
    end else if (st_r == ST_RECV && fall_tick) begin
      rx_r <= rx_nxt;
    end
  end

  // wire released once the address is out
  assign o_serial_memory_data_oe = (st_r == ST_SEND);
  assign o_serial_memory_data = tx_r[CMD_BITS-1];
  // clock tri-stated after the third word
  assign o_serial_memory_clock_oe = active;
  assign o_serial_memory_clock = sclk_r;
  assign o_pulldown_en = ~strap_n_s;

  // configuration latched once: straps when settling ends, the rest when the load ends or is skipped
  logic valid_r;
  logic [ID_W-1:0] vendor_id_r;
  logic [ID_W-1:0] product_id_r;
  logic [ID_W-1:0] word0_r;
  logic gang_r;
  logic bus_r;
  logic fast_r;

  // results appear only when the load ends or is skipped
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      valid_r <= 1'b0;
      vendor_id_r <= '0;
      product_id_r <= '0;
      word0_r <= '0;
      gang_r <= 1'b0;
    end else if (done_pulse) begin
      valid_r <= 1'b1;
      word0_r <= rx_nxt[3*ID_W-1:2*ID_W];
      gang_r <= rx_nxt[2*ID_W+GANG_BIT];
      vendor_id_r <= rx_nxt[2*ID_W-1:ID_W];
      product_id_r <= rx_nxt[ID_W-1:0];
    end else if (skip_pulse) begin
      // data pin doubles as the grouping strap when the memory is absent
      valid_r <= 1'b1;
      gang_r <= data_s;
      vendor_id_r <= DEF_VENDOR_ID;
      product_id_r <= DEF_PRODUCT_ID;
    end
  end

  // straps caught once, after they have settled through the sync
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bus_r <= 1'b0;
      fast_r <= 1'b0;
    end else if (st_r == ST_WAIT && cnt_r == SETTLE_LAST) begin
      bus_r <= bus_pwr_s;
      fast_r <= clk_src_s;
    end
  end

  assign o_cfg_valid = valid_r;
  assign o_vendor_identifier = vendor_id_r;
  assign o_product_identifier = product_id_r;
  assign o_ganged = gang_r;
  assign o_fast_clock_sel = fast_r;
  // mode from bus power strap and grouping
  assign o_power_mode = {bus_r, gang_r};

  // apb decode
  logic wr_en;
  logic rd_setup;
  assign wr_en = i_psel && i_penable && i_pwrite && addr_hit(i_paddr);
  assign rd_setup = i_psel && !i_penable;

  logic [PORTS-1:0] port_en_r;
  logic [PORTS-1:0] oc_hit;
  logic [PORTS-1:0] oc_prev_r;
  // ganged mode spreads one overcurrent to every port
  assign oc_hit = gang_r ? {PORTS{|oc_s}} : oc_s;

  // hardware shutdown beats a software enable in the same cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      port_en_r <= PORT_EN_RST;
    end else if (wr_en && i_paddr == ADDR_PORT_EN && valid_r) begin
      port_en_r <= i_pwdata[PORTS-1:0] & ~oc_hit;
    end else begin
      port_en_r <= port_en_r & ~oc_hit;
    end
  end
  assign o_port_power = port_en_r;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      oc_prev_r <= '0;
    end else begin
      oc_prev_r <= oc_s;
    end
  end

  // sticky status, write one to clear, new events win over the clear
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_clr;
  assign irq_ev = {oc_s & ~oc_prev_r, skip_pulse, done_pulse};
  assign irq_clr = (wr_en && i_paddr == ADDR_IRQ_STAT) ? i_pwdata[IRQ_W-1:0] : '0;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_mask_r <= IRQ_MASK_RST;
    end else if (wr_en && i_paddr == ADDR_IRQ_MASK) begin
      irq_mask_r <= i_pwdata[IRQ_W-1:0];
    end
  end

  assign o_irq = |(irq_stat_r & irq_mask_r);
  // read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_prdata <= '0;
    end else if (rd_setup) begin
      case (i_paddr)
        ADDR_PORT_EN: o_prdata <= DW'(port_en_r);
        ADDR_STATUS: o_prdata <= DW'({st_r, fast_r, bus_r, strap_n_s, gang_r, valid_r});
        ADDR_IRQ_STAT: o_prdata <= DW'(irq_stat_r);
        ADDR_IRQ_MASK: o_prdata <= DW'(irq_mask_r);
        ADDR_IDS: o_prdata <= {product_id_r, vendor_id_r};
        ADDR_WORD0: o_prdata <= DW'(word0_r);
        default: o_prdata <= '0;
      endcase
    end
  end

  // zero wait states; unmapped addresses answer with an error
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_hit(i_paddr);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  chk_pull_load: assert property ((st_r == ST_SEND) |-> o_pulldown_en)
    else $error("pull-downs off during memory load");
  chk_pull_off: assert property (strap_n_s |-> !o_pulldown_en && !o_serial_memory_data_oe)
    else $error("interface active while strap disables it");
  chk_one_load: assert property ((st_r == ST_DONE) |=> (st_r == ST_DONE) && !active)
    else $error("load sequence restarted");
  chk_start_bit: assert property ($rose(st_r == ST_SEND) |-> o_serial_memory_data
    && o_serial_memory_data_oe && !o_serial_memory_clock)
    else $error("start bit not driven at load start");
  chk_cmd_bits: assert property ((st_r == ST_SEND && fall_tick && cnt_r != '0)
    |=> !o_serial_memory_data)
    else $error("opcode or address bits not zero");
  chk_release: assert property ((st_r == ST_SEND) ##1 (st_r == ST_RECV)
    |-> !o_serial_memory_data_oe)
    else $error("data wire still driven after address");
  chk_sample_edge: assert property ((st_r == ST_RECV && fall_tick)
    |-> o_serial_memory_clock ##1 !o_serial_memory_clock)
    else $error("read data sampled at wrong clock phase");
  chk_hiz_done: assert property ($rose(st_r == ST_DONE) |-> !o_serial_memory_clock_oe
    && !o_serial_memory_data_oe && o_cfg_valid)
    else $error("pins not released after third word");
  chk_id_words: assert property (done_pulse |=>
    o_vendor_identifier == $past(rx_r[2*ID_W-2:ID_W-1]) &&
    o_product_identifier == {$past(rx_r[ID_W-2:0]), $past(data_s)})
    else $error("identifier words misplaced");
  chk_ganged_oc: assert property ((gang_r && |oc_s) |=> (o_port_power == '0))
    else $error("ganged overcurrent left a port powered");
  chk_valid_late: assert property ((active || st_r == ST_WAIT) |-> !o_cfg_valid
    && o_vendor_identifier == '0)
    else $error("configuration shown before load finished");
  chk_clock_src: assert property ((st_r == ST_WAIT && cnt_r == SETTLE_LAST)
    |=> o_fast_clock_sel == $past(clk_src_s))
    else $error("clock source select not taken from strap");
  cov_load_done: cover property ($rose(st_r == ST_DONE));
  cov_load_skip: cover property ($rose(st_r == ST_OFF));
  cov_irq: cover property ($rose(o_irq));
  cov_slverr: cover property (o_pslverr);
endmodule
`default_nettype wire

// *** rtl/hscl_pkg.sv ***
// constants and types shared by the hub serial configuration loader
package hscl_pkg;
  // system clock and serial memory clock timing
  localparam int unsigned SYS_CLK_NS = 100;
  localparam int unsigned SM_CLK_PERIOD_NS = 800;
  localparam int unsigned SM_HALF_CYC_RAW = SM_CLK_PERIOD_NS / (2 * SYS_CLK_NS);
  localparam int unsigned SM_HALF_CYC = (SM_HALF_CYC_RAW < 1) ? 1 : SM_HALF_CYC_RAW;
  localparam int unsigned SETTLE_NS = 400;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int PH_W = 4;
  localparam int CNT_W = 6;
  // serial memory transaction
  localparam int ID_W = 16;
  localparam int PORTS = 4;
  localparam int CMD_BITS = 8;
  localparam logic [CMD_BITS-1:0] READ_CMD = 8'hc0;
  localparam int WORDS = 3;
  localparam int RX_BITS = WORDS * ID_W;
  localparam int GANG_BIT = 14;
  // register map
  localparam int AW = 8;
  localparam int DW = 32;
  localparam logic [AW-1:0] ADDR_PORT_EN = 8'h00;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h04;
  localparam logic [AW-1:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [AW-1:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [AW-1:0] ADDR_IDS = 8'h10;
  localparam logic [AW-1:0] ADDR_WORD0 = 8'h14;
  localparam logic [PORTS-1:0] PORT_EN_RST = 4'h0;
  // interrupt status layout
  localparam int IRQ_W = 6;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_SKIP = 1;
  localparam int IRQ_OC_LSB = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 6'h00;
  // loader states, gray along wait-send-receive-done
  typedef enum logic [2:0] {
    ST_WAIT = 3'b000,
    ST_SEND = 3'b001,
    ST_RECV = 3'b011,
    ST_DONE = 3'b010,
    ST_OFF = 3'b110
  } hscl_state_e;
  // power mode: {bus powered, ganged}
  typedef enum logic [1:0] {
    PM_SELF_PORT = 2'b00,
    PM_SELF_GANG = 2'b01,
    PM_BUS_PORT = 2'b10,
    PM_BUS_GANG = 2'b11
  } hscl_pmode_e;
endpackage

// *** rtl/hscl_sync2.sv ***
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module hscl_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_r <= '0;
      o_q <= '0;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// *** sim/hscl_mem_model.sv ***
// behavioural three-wire serial memory beside the loader
`timescale 1ns/1ns
`default_nettype none
module hscl_mem_model #(
  parameter logic [47:0] CONTENT = 48'h0
) (
  input wire logic i_rstn,
  input wire logic i_sclk,
  input wire logic i_d,
  output logic o_q,
  output logic o_q_oe,
  output logic [7:0] o_cmd,
  output logic [7:0] o_rises
);
  // chip select follows power-on reset, so a reset restarts the sequence
  always @(posedge i_sclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rises <= 8'h00;
      o_cmd <= 8'h00;
      o_q_oe <= 1'b0;
      o_q <= 1'b0;
    end else begin
      o_rises <= o_rises + 8'h01;
      if (o_rises < 8'h08) begin
        o_cmd <= {o_cmd[6:0], i_d};
      end
      if (o_rises == 8'h07) begin
        o_q_oe <= 1'b1;
        o_q <= 1'b0;
      end
      if (o_rises >= 8'h08 && o_rises < 8'h38) begin
        o_q <= CONTENT[8'h37-o_rises];
      end
      if (o_rises == 8'h38) begin
        o_q_oe <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench for the serial configuration loader
`timescale 1ns/1ns
`default_nettype none
module tb;
  import hscl_pkg::*;
  localparam logic [15:0] W0 = 16'h4000;
  localparam logic [15:0] MEM_VENDOR = 16'hc3a5; // arbitrary test value
  localparam logic [15:0] MEM_PRODUCT = 16'h5a3c; // arbitrary test value
  localparam logic [15:0] DEF_VENDOR = 16'h1357; // arbitrary test value
  localparam logic [15:0] DEF_PRODUCT = 16'h2468; // arbitrary test value
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic strap_n = 1'b0, bus_pwr = 1'b0, clk_src = 1'b0, gang_tie = 1'b0;
  logic [3:0] oc_n = 4'hf;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sclk, sclk_oe, sdo, sdo_oe, pd_en, cfg_valid, ganged, fast_sel;
  logic pready, pslverr, irq, mq, mq_oe;
  logic [15:0] vendor_id, product_id;
  logic [1:0] pmode;
  logic [3:0] port_pwr;
  logic [31:0] prdata;
  logic [7:0] cmd, rises;
  wire sdata = sdo_oe ? sdo : (mq_oe ? mq : (pd_en ? 1'b0 : gang_tie));
  int n_mismatch = 0;
  int total_checks = 0;
  always #50 i_clk = ~i_clk;
  hscl_loader #(.DEF_VENDOR_ID(DEF_VENDOR), .DEF_PRODUCT_ID(DEF_PRODUCT)) dut (
    .i_clk(i_clk), .i_rstn(i_rstn),
    .i_external_memory_strap_n(strap_n), .i_bus_power_strap(bus_pwr),
    .i_clock_source_strap(clk_src), .o_serial_memory_clock(sclk),
    .o_serial_memory_clock_oe(sclk_oe), .i_serial_memory_data(sdata),
    .o_serial_memory_data(sdo), .o_serial_memory_data_oe(sdo_oe), .o_pulldown_en(pd_en),
    .o_cfg_valid(cfg_valid), .o_vendor_identifier(vendor_id),
    .o_product_identifier(product_id),
    .o_ganged(ganged), .o_power_mode(pmode), .o_fast_clock_sel(fast_sel),
    .i_overcurrent_n(oc_n), .o_port_power(port_pwr), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq));
  hscl_mem_model #(.CONTENT({W0, MEM_VENDOR, MEM_PRODUCT})) mem (.i_rstn(i_rstn),
    .i_sclk(sclk_oe & sclk), .i_d(sdata), .o_q(mq), .o_q_oe(mq_oe), .o_cmd(cmd),
    .o_rises(rises));

  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_clk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a wait for the slave
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("apb ready", 1'b1, pready);
  endtask

  task automatic do_reset(input logic s_n, input logic bp, input logic cs, input logic g);
    @(posedge i_clk);
    i_rstn <= 1'b0;
    strap_n <= s_n;
    bus_pwr <= bp;
    clk_src <= cs;
    gang_tie <= g;
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
  endtask

  task automatic wait_ports(input logic [3:0] exp);
    int k;
    k = 0;
    while (port_pwr !== exp && k < 12) begin
      @(posedge i_clk);
      k++;
    end
  endtask

  task automatic t_load();
    int k;
    do_reset(1'b0, 1'b1, 1'b1, 1'b0);
    @(posedge i_clk);
    check("ids before load", 33'h0, {cfg_valid, vendor_id, product_id});
    k = 0;
    while (cfg_valid !== 1'b1 && k < 600) begin
      @(posedge i_clk);
      k++;
    end
    check("pull-downs", 1'b1, pd_en);
    check("command bits", {1'h1, 2'h2, 5'h00}, cmd);
    check("vendor id", MEM_VENDOR, vendor_id);
    check("product id", MEM_PRODUCT, product_id);
    check("grouping", W0[14], ganged);
    check("power mode", {1'b1, W0[14]}, pmode);
    check("fast clock", 1'b1, fast_sel);
    check("pins released", 2'h0, {sclk_oe, sdo_oe});
    // long idle span so a repeated read would show in the edge count
    repeat (1000) @(posedge i_clk);
    check("clock rises", CMD_BITS + RX_BITS, rises);
  endtask

  task automatic t_regs();
    logic [31:0] rd;
    logic e;
    apb(1'b0, ADDR_IRQ_MASK, 32'h0, rd, e);
    check("mask reset", 32'h0, rd);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0, rd, e);
    check("done status", 32'h1 << IRQ_DONE, rd);
    check("masked irq", 1'b0, irq);
    apb(1'b1, ADDR_IRQ_MASK, 32'h1 << IRQ_DONE, rd, e);
    @(negedge i_clk);
    check("irq raised", 1'b1, irq);
    apb(1'b1, ADDR_IRQ_STAT, 32'h1 << IRQ_DONE, rd, e);
    @(negedge i_clk);
    check("irq cleared", 1'b0, irq);
    apb(1'b0, 8'h40, 32'h0, rd, e);
    check("unmapped", 33'h1_0000_0000, {e, rd});
    apb(1'b0, ADDR_IDS, 32'h0, rd, e);
    check("ids register", {MEM_PRODUCT, MEM_VENDOR}, rd);
    apb(1'b0, ADDR_WORD0, 32'h0, rd, e);
    check("word0 register", {16'h0, W0}, rd);
    apb(1'b0, ADDR_STATUS, 32'h0, rd, e);
    check("status register", {ST_DONE, 1'b1, 1'b1, 1'b0, W0[14], 1'b1}, rd);
  endtask

  task automatic t_ports(input logic [3:0] oc, input logic [3:0] exp);
    logic [31:0] rd;
    logic e;
    apb(1'b1, ADDR_PORT_EN, 32'hf, rd, e);
    apb(1'b0, ADDR_PORT_EN, 32'h0, rd, e);
    check("port enable", 32'hf, rd);
    oc_n <= oc;
    wait_ports(exp);
    check("port power", exp, port_pwr);
    oc_n <= 4'hf;
  endtask

  task automatic t_nomem();
    logic [31:0] rd;
    logic e;
    int k;
    do_reset(1'b1, 1'b0, 1'b0, 1'b0);
    k = 0;
    while (cfg_valid !== 1'b1 && k < 50) begin
      @(posedge i_clk);
      k++;
    end
    check("no pull-downs", 2'h0, {pd_en, sclk_oe});
    check("default ids", {DEF_VENDOR, DEF_PRODUCT}, {vendor_id, product_id});
    check("mode and clock", 3'h0, {pmode, fast_sel});
    apb(1'b0, ADDR_IRQ_STAT, 32'h0, rd, e);
    check("skip status", 32'h1 << IRQ_SKIP, rd);
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    test_done();
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    t_load();
    t_regs();
    t_ports(4'hb, 4'h0);
    t_nomem();
    t_ports(4'hd, 4'hd);
    test_done();
  end
endmodule
`default_nettype wire
